// ===== logic/cdb_cfg.svh
// offsets, field positions and reset values of the config bridge block
`ifndef CDB_CFG_SVH
`define CDB_CFG_SVH
`define CDB_OFF_CTRL      8'h00
`define CDB_OFF_BUS       8'h04
`define CDB_OFF_CFG_ADDR  8'h08
`define CDB_OFF_CFG_AD    8'h0c
`define CDB_OFF_CFG_STAT  8'h10
`define CDB_OFF_IO_REQ    8'h14
`define CDB_OFF_IO_STAT   8'h18
`define CDB_OFF_COUNT     8'h1c
`define CDB_CTRL_IDE_PRI  0
`define CDB_CTRL_IDE_SEC  1
`define CDB_CTRL_POS_DEC  2
`define CDB_CTRL_RST      3'h0
`define CDB_BUS_RST       24'h000000
`define CDB_CFG_EN_BIT    31
`define CDB_DEV_BRIDGE    5'h1e
`define CDB_DEV_FUNCS     5'h1f
`define CDB_AD_BRIDGE     14
`define CDB_AD_FUNCS      15
`define CDB_AD_IDSEL_LO   16
`define CDB_IO_WR_BIT     16
`define CDB_IO_PCI_BIT    17
`endif

// ===== logic/cdb_pkg.sv
// types shared by the config bridge modules
package cdb_pkg;
    typedef enum logic [1:0] {
        CDB_CFG_NONE,
        CDB_CFG_TYPE0,
        CDB_CFG_TYPE1
    } cdb_cfg_kind_t;

    typedef enum logic [3:0] {
        CDB_IO_NONE,
        CDB_IO_PCI,
        CDB_IO_LPC,
        CDB_IO_DMA,
        CDB_IO_INTR,
        CDB_IO_PIT,
        CDB_IO_NMI,
        CDB_IO_NMI_RTC,
        CDB_IO_RTC,
        CDB_IO_RESET,
        CDB_IO_PM,
        CDB_IO_IDE,
        CDB_IO_PROC
    } cdb_io_tgt_t;

    typedef struct packed {
        logic [31:0]   ad;
        cdb_cfg_kind_t kind;
        logic          self_claim;
    } cdb_cfg_res_t;
endpackage

// ===== logic/cdb_io_if.sv
// request and answer of the fixed i/o decoder
`timescale 1ns/100ps
interface cdb_io_if;
    import cdb_pkg::*;
    logic [15:0] addr;
    logic        is_write;
    logic        from_pci;
    logic        ide_pri_en;
    logic        ide_sec_en;
    logic        positive_decode_enable;
    cdb_io_tgt_t target;
    logic        claimed;
    logic        dual_fwd;
    logic        medium_devsel;

    modport requester (
        output addr, is_write, from_pci, ide_pri_en, ide_sec_en,
        output positive_decode_enable,
        input  target, claimed, dual_fwd, medium_devsel
    );
    modport decoder (
        input  addr, is_write, from_pci, ide_pri_en, ide_sec_en,
        input  positive_decode_enable,
        output target, claimed, dual_fwd, medium_devsel
    );
endinterface

// ===== logic/cdb_io_decode.sv
// fixed i/o range decoder
`timescale 1ns/100ps
`include "cdb_cfg.svh"
module cdb_io_decode (
    cdb_io_if.decoder io
);
    import cdb_pkg::*;

    // hard-wired table; unit enables only gate, never move, a range
    function automatic cdb_io_tgt_t fixed_tgt(
        input logic [15:0] a,
        input logic        wr,
        input logic        pri,
        input logic        sec,
        input logic        pde
    );
        cdb_io_tgt_t t;
        logic [7:0]  lo;
        t  = CDB_IO_NONE;
        lo = a[7:0];
        if (a[15:8] == 8'h00)
        begin
            if (lo <= 8'h1f)
            begin
                if (wr || !((lo >= 8'h09 && lo <= 8'h0e) ||
                            (lo >= 8'h19 && lo <= 8'h1e)))
                    t = CDB_IO_DMA;
            end
            else if (lo[7:5] == 3'h1 && !lo[1])
                t = CDB_IO_INTR;
            else if ((lo >= 8'h40 && lo <= 8'h42) ||
                     (lo >= 8'h50 && lo <= 8'h52))
                t = CDB_IO_PIT;
            else if ((lo == 8'h43 || lo == 8'h53) && wr)
                t = CDB_IO_PIT;
            else if (lo == 8'h61)
                t = CDB_IO_NMI;
            else if (lo >= 8'h70 && lo <= 8'h77)
            begin
                if (wr && !lo[0])
                    t = CDB_IO_NMI_RTC;
                else if (lo != 8'h70)
                    t = CDB_IO_RTC;
            end
            else if (lo[7:4] == 4'h8)
                t = CDB_IO_DMA;
            else if (lo == 8'h92)
                t = CDB_IO_RESET;
            else if (lo == 8'hb2 || lo == 8'hb3)
                t = CDB_IO_PM;
            else if (lo[7:5] == 3'h5 && !lo[1])
                t = CDB_IO_INTR;
            else if (lo >= 8'hc0 && lo <= 8'hdf)
            begin
                if (wr || !(lo >= 8'hd2 && lo <= 8'hdd))
                    t = CDB_IO_DMA;
            end
            else if (lo == 8'hf0)
            begin
                if (wr)
                    t = CDB_IO_PROC;
                else if (!pde)
                    t = CDB_IO_LPC;
            end
        end
        else if ((a >= 16'h0170 && a <= 16'h0177) || a == 16'h0376)
        begin
            if (pri)
                t = CDB_IO_IDE;
        end
        else if ((a >= 16'h01f0 && a <= 16'h01f7) || a == 16'h03f6)
        begin
            if (sec)
                t = CDB_IO_IDE;
        end
        else if (a == 16'h04d0 || a == 16'h04d1)
            t = CDB_IO_INTR;
        else if (a == 16'h0cf9)
            t = CDB_IO_RESET;
        return t;
    endfunction

    cdb_io_tgt_t fixed_hit_tgt;
    wire         fixed_hit;
    wire         page_loc;

    assign fixed_hit_tgt = fixed_tgt(io.addr, io.is_write, io.ide_pri_en,
                                     io.ide_sec_en,
                                     io.positive_decode_enable);
    assign fixed_hit = fixed_hit_tgt != CDB_IO_NONE;
    assign page_loc  = io.addr[15:8] == 8'h00 && io.addr[7:4] == 4'h8 &&
                       (io.addr[3:0] == 4'h0 || io.addr[3:0] == 4'h8 ||
                        (io.addr[2] && io.addr[1:0] != 2'h3));
    // upstream misses fall through to pci, pci-side misses stay unclaimed
    assign io.target        = fixed_hit ? fixed_hit_tgt :
                              (io.from_pci ? CDB_IO_NONE : CDB_IO_PCI);
    assign io.claimed       = fixed_hit;
    assign io.dual_fwd      = page_loc && io.is_write;
    assign io.medium_devsel = fixed_hit && io.from_pci;
endmodule

// ===== logic/cdb_bridge.sv
// config cycle translator and fixed i/o decoder with apb registers
`timescale 1ns/100ps
`include "cdb_cfg.svh"
module cdb_bridge #(
    parameter int APB_AW = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [APB_AW-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      cfg_start,
    output logic      [31:0]          cfg_pci_ad,
    output cdb_pkg::cdb_cfg_kind_t    cfg_kind,
    output logic                      cfg_self_claim,
    output logic                      io_dec_valid,
    output cdb_pkg::cdb_io_tgt_t      io_dec_target,
    output logic                      io_dec_claimed,
    output logic                      io_dec_dual_fwd,
    output logic                      io_dec_medium_devsel
);
    import cdb_pkg::*;

    initial
    begin
        if (APB_AW < 5 || APB_AW > 32)
            $error("APB_AW must lie between 5 and 32");
    end

    // type 0 / type 1 address building for a mechanism one address
    function automatic cdb_cfg_res_t cfg_translate(
        input logic [31:0] a,
        input logic [7:0]  sec_bus,
        input logic [7:0]  sub_bus
    );
        cdb_cfg_res_t r;
        logic [7:0]   bus;
        logic [4:0]   dev;
        bus          = a[23:16];
        dev          = a[15:11];
        r.ad         = 32'h00000000;
        r.kind       = CDB_CFG_NONE;
        r.self_claim = 1'b0;
        if (bus == 8'h00)
        begin
            r.kind     = CDB_CFG_TYPE0;
            r.ad[10:2] = a[10:2];
            if (dev == `CDB_DEV_BRIDGE)
            begin
                r.ad[`CDB_AD_BRIDGE] = 1'b1;
                r.self_claim = 1'b1;
            end
            else if (dev == `CDB_DEV_FUNCS)
            begin
                r.ad[`CDB_AD_FUNCS] = 1'b1;
                r.self_claim = 1'b1;
            end
            // any other device keeps 31:11 at zero
        end
        else if (bus == sec_bus)
        begin
            r.kind = CDB_CFG_TYPE0;
            if (!dev[4])
                r.ad[`CDB_AD_IDSEL_LO + int'(dev[3:0])] = 1'b1;
            r.ad[15:11] = 5'h00;
            r.ad[10:1]  = a[10:1];
            r.ad[0]     = 1'b0;
        end
        else if (bus > sec_bus && bus <= sub_bus)
        begin
            r.kind = CDB_CFG_TYPE1;
            r.ad   = {8'h00, a[23:2], 2'b01};
        end
        return r;
    endfunction

    logic [2:0]    ctrl_reg;
    logic [23:0]   bus_reg;
    logic [31:0]   cfg_addr_reg;
    logic [17:0]   io_req_reg;
    logic [15:0]   cfg_cnt_reg;
    logic [15:0]   io_cnt_reg;
    logic [31:0]   prdata_reg;
    logic [31:0]   prdata_next;
    logic          pready_reg;
    logic          pslverr_reg;
    logic          cfg_start_reg;
    logic [31:0]   cfg_ad_reg;
    cdb_cfg_kind_t cfg_kind_reg;
    logic          cfg_self_reg;
    logic          io_valid_reg;
    cdb_io_tgt_t   io_tgt_reg;
    logic          io_claim_reg;
    logic          io_dual_reg;
    logic          io_med_reg;

    cdb_io_if      io_bus ();
    cdb_cfg_res_t  cfg_res;

    wire [7:0] reg_off    = 8'(paddr[APB_AW-1:0]);
    wire       setup_ph   = psel && !penable;
    wire       access_ok  = psel && penable && pready_reg;
    wire       wr_go      = access_ok && pwrite && !pslverr_reg;
    wire       hit_ctrl   = reg_off == `CDB_OFF_CTRL;
    wire       hit_bus    = reg_off == `CDB_OFF_BUS;
    wire       hit_caddr  = reg_off == `CDB_OFF_CFG_ADDR;
    wire       hit_cad    = reg_off == `CDB_OFF_CFG_AD;
    wire       hit_cstat  = reg_off == `CDB_OFF_CFG_STAT;
    wire       hit_ioreq  = reg_off == `CDB_OFF_IO_REQ;
    wire       hit_iostat = reg_off == `CDB_OFF_IO_STAT;
    wire       hit_count  = reg_off == `CDB_OFF_COUNT;
    wire       mapped     = hit_ctrl || hit_bus || hit_caddr || hit_cad ||
                            hit_cstat || hit_ioreq || hit_iostat ||
                            hit_count;
    // mechanism two has no port here: a cleared enable bit just stores
    wire       cfg_go     = wr_go && hit_caddr &&
                            pwdata[`CDB_CFG_EN_BIT];
    wire       io_go      = wr_go && hit_ioreq;

    assign cfg_res = cfg_translate(pwdata, bus_reg[15:8],
                                   bus_reg[23:16]);

    // decoder sees the written word directly so the answer lands at once
    assign io_bus.addr                   = pwdata[15:0];
    assign io_bus.is_write               = pwdata[`CDB_IO_WR_BIT];
    assign io_bus.from_pci               = pwdata[`CDB_IO_PCI_BIT];
    assign io_bus.ide_pri_en             = ctrl_reg[`CDB_CTRL_IDE_PRI];
    assign io_bus.ide_sec_en             = ctrl_reg[`CDB_CTRL_IDE_SEC];
    assign io_bus.positive_decode_enable = ctrl_reg[`CDB_CTRL_POS_DEC];

    cdb_io_decode u_io_decode (
        .io (io_bus.decoder)
    );

    always_comb
    begin
        prdata_next = 32'h00000000;
        case (1'b1)
            hit_ctrl:   prdata_next = {29'h0, ctrl_reg};
            hit_bus:    prdata_next = {8'h00, bus_reg};
            hit_caddr:  prdata_next = cfg_addr_reg;
            hit_cad:    prdata_next = cfg_ad_reg;
            hit_cstat:  prdata_next = {29'h0, cfg_self_reg, cfg_kind_reg};
            hit_ioreq:  prdata_next = {14'h0, io_req_reg};
            hit_iostat: prdata_next = {25'h0, io_med_reg, io_dual_reg,
                                       io_claim_reg, io_tgt_reg};
            hit_count:  prdata_next = {io_cnt_reg, cfg_cnt_reg};
            default:    prdata_next = 32'h00000000;
        endcase
    end

    // apb answer: ready rises on the setup edge, so access takes one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end
        else
        begin
            pready_reg  <= setup_ph;
            pslverr_reg <= setup_ph && !mapped;
            if (setup_ph)
                prdata_reg <= pwrite ? 32'h00000000 : prdata_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg     <= `CDB_CTRL_RST;
            bus_reg      <= `CDB_BUS_RST;
            cfg_addr_reg <= 32'h00000000;
            io_req_reg   <= 18'h00000;
        end
        else if (wr_go)
        begin
            if (hit_ctrl)
                ctrl_reg <= pwdata[2:0];
            if (hit_bus)
                bus_reg <= pwdata[23:0];
            if (hit_caddr)
                cfg_addr_reg <= pwdata;
            if (hit_ioreq)
                io_req_reg <= pwdata[17:0];
        end
    end

    // at most one start pulse per request (none on a bus miss) and no address advance: single dword
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_start_reg <= 1'b0;
            cfg_ad_reg    <= 32'h00000000;
            cfg_kind_reg  <= CDB_CFG_NONE;
            cfg_self_reg  <= 1'b0;
            cfg_cnt_reg   <= 16'h0000;
        end
        else
        begin
            cfg_start_reg <= cfg_go && cfg_res.kind != CDB_CFG_NONE;
            if (cfg_go)
            begin
                cfg_ad_reg   <= cfg_res.ad;
                cfg_kind_reg <= cfg_res.kind;
                cfg_self_reg <= cfg_res.self_claim;
                if (cfg_res.kind != CDB_CFG_NONE)
                    cfg_cnt_reg <= cfg_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_valid_reg <= 1'b0;
            io_tgt_reg   <= CDB_IO_NONE;
            io_claim_reg <= 1'b0;
            io_dual_reg  <= 1'b0;
            io_med_reg   <= 1'b0;
            io_cnt_reg   <= 16'h0000;
        end
        else
        begin
            io_valid_reg <= io_go;
            if (io_go)
            begin
                io_tgt_reg   <= io_bus.target;
                io_claim_reg <= io_bus.claimed;
                io_dual_reg  <= io_bus.dual_fwd;
                io_med_reg   <= io_bus.medium_devsel;
                if (io_bus.claimed)
                    io_cnt_reg <= io_cnt_reg + 16'h0001;
            end
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign cfg_start            = cfg_start_reg;
    assign cfg_pci_ad           = cfg_ad_reg;
    assign cfg_kind             = cfg_kind_reg;
    assign cfg_self_claim       = cfg_self_reg;
    assign io_dec_valid         = io_valid_reg;
    assign io_dec_target        = io_tgt_reg;
    assign io_dec_claimed       = io_claim_reg;
    assign io_dec_dual_fwd      = io_dual_reg;
    assign io_dec_medium_devsel = io_med_reg;
endmodule

// ===== testbench/cdb_bridge_chk.sv
// assertions on the config bridge top-level ports
`timescale 1ns/100ps
module cdb_bridge_chk
    import cdb_pkg::*;
#(
    parameter int APB_AW = 8
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [APB_AW-1:0]    paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 cfg_start,
    input wire logic [31:0]          cfg_pci_ad,
    input cdb_pkg::cdb_cfg_kind_t    cfg_kind,
    input wire logic                 cfg_self_claim,
    input wire logic                 io_dec_valid,
    input cdb_pkg::cdb_io_tgt_t      io_dec_target,
    input wire logic                 io_dec_claimed,
    input wire logic                 io_dec_dual_fwd,
    input wire logic                 io_dec_medium_devsel
);
    logic [31:0] cfg_cap;
    logic [23:0] bus_cap;
    logic [17:0] io_cap;
    wire logic       done_wr = psel && penable && pready && pwrite;
    wire logic [7:0] bus_f = cfg_cap[23:16];
    wire logic [4:0] dev_f = cfg_cap[15:11];
    wire logic       conv = cfg_start && bus_f != 8'h00
                         && cfg_kind == CDB_CFG_TYPE0;
    // shadows of the last request, so outputs can be tied to their cause
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_cap <= 32'h0;
            bus_cap <= 24'h0;
            io_cap  <= 18'h0;
        end
        else if (done_wr)
        begin
            if (paddr[7:0] == 8'h08) cfg_cap <= pwdata;
            if (paddr[7:0] == 8'h04) bus_cap <= pwdata[23:0];
            if (paddr[7:0] == 8'h14) io_cap <= pwdata[17:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_cfg_off;
        done_wr && paddr[7:0] == 8'h08 && !pwdata[31];
    endsequence
    a_apb_one_wait: assert property (s_setup |=> pready)
        else $error("apb access not answered in one cycle");
    a_cfg_mech_one: assert property (s_cfg_off |=> !cfg_start)
        else $error("config cycle without enable bit");
    a_cfg_single_pulse: assert property (cfg_start |=> !cfg_start)
        else $error("config start longer than one cycle");
    a_own_dev_bits: assert property (cfg_start && bus_f == 8'h00
        && dev_f >= 5'h1e |-> cfg_self_claim
        && cfg_pci_ad[15:14] == (dev_f[0] ? 2'b10 : 2'b01))
        else $error("own device bits wrong");
    a_other_dev_low: assert property (cfg_start && bus_f == 8'h00
        && dev_f < 5'h1e |-> cfg_pci_ad[31:11] == 21'h0)
        else $error("foreign device set high address bits");
    a_sec_to_type0: assert property (cfg_start && bus_f != 8'h00
        && bus_f == bus_cap[15:8] |-> cfg_kind == CDB_CFG_TYPE0)
        else $error("secondary bus cycle not type 0");
    a_sub_to_type1: assert property (cfg_start
        && bus_f > bus_cap[15:8] && bus_f <= bus_cap[23:16]
        |-> cfg_kind == CDB_CFG_TYPE1 && cfg_pci_ad[0])
        else $error("downstream bus cycle not type 1");
    a_conv_idsel: assert property (conv && !dev_f[4]
        |-> cfg_pci_ad[31:16] == 16'h0001 << dev_f)
        else $error("converted idsel bit wrong");
    a_conv_zero: assert property (conv
        |-> cfg_pci_ad[15:11] == 5'h00 && !cfg_pci_ad[0])
        else $error("converted low bits not cleared");
    a_conv_copy: assert property (conv
        |-> cfg_pci_ad[10:1] == cfg_cap[10:1])
        else $error("converted bits 10 to 1 altered");
    a_dual_dma: assert property (io_dec_valid && io_dec_dual_fwd
        |-> io_dec_target == CDB_IO_DMA && io_cap[16])
        else $error("dual forward outside dma page write");
    a_up_miss_pci: assert property (io_dec_valid && !io_dec_claimed
        && !io_cap[17] |-> io_dec_target == CDB_IO_PCI)
        else $error("unclaimed upstream cycle not sent to pci");
    a_pci_medium: assert property (io_dec_valid && io_dec_claimed
        && io_cap[17] |-> io_dec_medium_devsel)
        else $error("pci master hit without medium devsel");
endmodule
bind cdb_bridge cdb_bridge_chk #(.APB_AW(APB_AW)) u_chk (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .cfg_start(cfg_start), .cfg_pci_ad(cfg_pci_ad), .cfg_kind(cfg_kind),
    .cfg_self_claim(cfg_self_claim), .io_dec_valid(io_dec_valid),
    .io_dec_target(io_dec_target), .io_dec_claimed(io_dec_claimed),
    .io_dec_dual_fwd(io_dec_dual_fwd),
    .io_dec_medium_devsel(io_dec_medium_devsel));

// ===== testbench/cdb_pci_model.sv
// pci side model that takes each issued config cycle
`timescale 1ns/100ps
module cdb_pci_model
    import cdb_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 cfg_start,
    input wire logic [31:0]          cfg_pci_ad,
    input cdb_pkg::cdb_cfg_kind_t    cfg_kind,
    input wire logic                 cfg_self_claim,
    output logic     [31:0]          seen_ad,
    output cdb_pkg::cdb_cfg_kind_t   seen_kind,
    output logic                     seen_claim,
    output logic     [15:0]          seen_count
);
    // one start is one single dword transfer, bursts cannot be expressed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_ad    <= 32'h0;
            seen_kind  <= CDB_CFG_NONE;
            seen_claim <= 1'b0;
            seen_count <= 16'h0;
        end
        else if (cfg_start)
        begin
            seen_ad    <= cfg_pci_ad;
            seen_kind  <= cfg_kind;
            seen_claim <= cfg_self_claim;
            seen_count <= seen_count + 16'h1;
        end
    end
endmodule

// ===== testbench/cdb_bridge_bench.sv
// random and corner tests of the config bridge
`timescale 1ns/100ps
module cdb_bridge_bench;
    import cdb_pkg::*;
    logic          clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr, sec, sub, b;
    logic [31:0]   pwdata, prdata, cfg_pci_ad, seen_ad, r, a;
    logic          cfg_start, cfg_self_claim, seen_claim, e;
    logic          io_dec_valid, io_dec_claimed;
    logic          io_dec_dual_fwd, io_dec_medium_devsel;
    logic [15:0]   seen_count;
    cdb_cfg_kind_t cfg_kind, seen_kind;
    cdb_io_tgt_t   io_dec_target;
    int            failures, compares, k;
    cdb_bridge u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_start(cfg_start), .cfg_pci_ad(cfg_pci_ad), .cfg_kind(cfg_kind),
        .cfg_self_claim(cfg_self_claim), .io_dec_valid(io_dec_valid),
        .io_dec_target(io_dec_target), .io_dec_claimed(io_dec_claimed),
        .io_dec_dual_fwd(io_dec_dual_fwd),
        .io_dec_medium_devsel(io_dec_medium_devsel));
    cdb_pci_model u_pci (.clk(clk), .rst_n(rst_n), .cfg_start(cfg_start),
        .cfg_pci_ad(cfg_pci_ad), .cfg_kind(cfg_kind),
        .cfg_self_claim(cfg_self_claim), .seen_ad(seen_ad),
        .seen_kind(seen_kind), .seen_claim(seen_claim),
        .seen_count(seen_count));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic test_done;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // request held until pready seen; read data taken before release
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            $display("ERROR %0t apb no ready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] mk(logic [7:0] bu, logic [4:0] dv,
                                       logic [2:0] fn, logic [5:0] rg);
        return {1'b1, 7'h00, bu, dv, fn, rg, 2'b00};
    endfunction
    function automatic cdb_cfg_res_t exp_cfg(logic [31:0] x);
        cdb_cfg_res_t t;
        t = '0;
        if (x[23:16] == 8'h00)
        begin
            t.kind = CDB_CFG_TYPE0;
            t.ad[10:2] = x[10:2];
            t.ad[14] = x[15:11] == 5'h1e;
            t.ad[15] = x[15:11] == 5'h1f;
            t.self_claim = x[15:11] >= 5'h1e;
        end
        else if (x[23:16] == sec)
        begin
            t.kind = CDB_CFG_TYPE0;
            t.ad[10:1] = x[10:1];
            if (!x[15]) t.ad[16 + x[14:11]] = 1'b1;
        end
        else if (x[23:16] > sec && x[23:16] <= sub)
            t = '{ {8'h00, x[23:2], 2'b01}, CDB_CFG_TYPE1, 1'b0 };
        return t;
    endfunction
    task automatic cfg(input logic [31:0] x);
        cdb_cfg_res_t t;
        logic [15:0]  n0;
        t = x[31] ? exp_cfg(x) : '0;
        n0 = seen_count;
        apb(1'b1, 8'h08, x, r, e);
        @(posedge clk);
        @(negedge clk);
        if (t.kind == CDB_CFG_NONE)
            chk({16'h0, seen_count}, {16'h0, n0}, "spurious cycle");
        else
        begin
            chk({16'h0, seen_count}, {16'h0, n0 + 16'h1}, "count");
            chk(seen_ad, t.ad, "pci ad");
            chk({29'h0, seen_kind, seen_claim},
                {29'h0, t.kind, t.self_claim}, "kind");
        end
    endtask
    task automatic io(input logic [2:0] c, input logic [15:0] ad,
                      input logic w, input logic p, input cdb_io_tgt_t t,
                      input logic cl, input logic du);
        apb(1'b1, 8'h00, {29'h0, c}, r, e);
        apb(1'b1, 8'h14, {14'h0, p, w, ad}, r, e);
        @(negedge clk);
        chk({24'h0, io_dec_valid, io_dec_target, io_dec_claimed,
             io_dec_dual_fwd, io_dec_medium_devsel},
            {24'h0, 1'b1, t, cl, du, cl & p}, "io decode");
    endtask
    initial
    begin
        #400000;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        test_done;
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        failures = 0;
        compares = 0;
        void'($urandom(38));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, r, e);
        chk(r, 32'h0, "ctrl reset");
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({31'h0, e}, 32'h1, "unmapped");
        sec = 8'h01 + 8'($urandom % 100);
        sub = sec + 8'h03;
        apb(1'b1, 8'h04, {8'h00, sub, sec, 8'h00}, r, e);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk(r, {8'h00, sub, sec, 8'h00}, "bus numbers");
        cfg(mk(8'h00, 5'h1e, 3'h0, 6'h02));
        cfg(mk(8'h00, 5'h1f, 3'h5, 6'h3f));
        cfg(mk(8'h00, 5'h1d, 3'h7, 6'h15));
        cfg(mk(sec, 5'h00, 3'h2, 6'h2a));
        cfg(mk(sec, 5'h0f, 3'h7, 6'h3f));
        cfg(mk(sec, 5'h10, 3'h1, 6'h01));
        cfg(mk(sub, 5'h03, 3'h4, 6'h10));
        cfg(mk(sub + 8'h01, 5'h03, 3'h0, 6'h00));
        cfg(mk(sec, 5'h01, 3'h0, 6'h00) & 32'h7fffffff);
        repeat (60)
        begin
            k = $urandom % 4;
            b = k == 0 ? 8'h00 : k == 1 ? sec : k == 2
                ? sec + 8'($urandom % 4) : 8'($urandom);
            a = mk(b, 5'($urandom), 3'($urandom), 6'($urandom));
            if ($urandom % 8 == 0) a[31] = 1'b0;
            cfg(a);
        end
        io(3'h0, 16'h0080, 1'b1, 1'b0, CDB_IO_DMA, 1'b1, 1'b1);
        io(3'h0, 16'h0080, 1'b0, 1'b0, CDB_IO_DMA, 1'b1, 1'b0);
        io(3'h0, 16'h008e, 1'b1, 1'b0, CDB_IO_DMA, 1'b1, 1'b1);
        io(3'h0, 16'h0081, 1'b1, 1'b0, CDB_IO_DMA, 1'b1, 1'b0);
        io(3'h0, 16'h0070, 1'b1, 1'b0, CDB_IO_NMI_RTC, 1'b1, 1'b0);
        io(3'h0, 16'h0076, 1'b1, 1'b0, CDB_IO_NMI_RTC, 1'b1, 1'b0);
        io(3'h0, 16'h0070, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h0, 16'h0009, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h0, 16'h0170, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h1, 16'h0177, 1'b0, 1'b0, CDB_IO_IDE, 1'b1, 1'b0);
        io(3'h1, 16'h0376, 1'b1, 1'b0, CDB_IO_IDE, 1'b1, 1'b0);
        io(3'h1, 16'h01f0, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h2, 16'h03f6, 1'b0, 1'b0, CDB_IO_IDE, 1'b1, 1'b0);
        io(3'h0, 16'h00f0, 1'b0, 1'b0, CDB_IO_LPC, 1'b1, 1'b0);
        io(3'h4, 16'h00f0, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h4, 16'h00f0, 1'b1, 1'b0, CDB_IO_PROC, 1'b1, 1'b0);
        io(3'h0, 16'h0300, 1'b0, 1'b0, CDB_IO_PCI, 1'b0, 1'b0);
        io(3'h0, 16'h0300, 1'b0, 1'b1, CDB_IO_NONE, 1'b0, 1'b0);
        io(3'h0, 16'h0040, 1'b0, 1'b1, CDB_IO_PIT, 1'b1, 1'b0);
        io(3'h0, 16'h0020, 1'b1, 1'b1, CDB_IO_INTR, 1'b1, 1'b0);
        io(3'h0, 16'h0092, 1'b1, 1'b0, CDB_IO_RESET, 1'b1, 1'b0);
        test_done;
    end
endmodule
